// ==== verilog/pwm_pkg.sv ====
// constants shared by the six-channel motor waveform unit
// assumes one clock, synchronous active-high reset, no register bus
//
// Contract
// - six generators, independent or three pairs
// - complementary pair outputs inverse with dead zone
// - one 8-bit prescaler per channel pair
// - per-channel divider: 1, 1/2, 1/4, 1/8, 1/16
// - 16-bit period counter, 16-bit duty compare
// - twelve flags: period and duty match
// - flag raises interrupt only when enabled
// - one-shot single cycle or continuous auto-reload
// - one-shot edge only; centre needs auto-reload
// - period counter counts down, 16 bits; in centre mode the code counts back up from zero to the period value
// - buffered period/duty load at period end
// - synchronous pairing drives pair in phase
// - group bit: 2,4 follow 0; 3,5 follow 1
// - edge-aligned and centre-aligned counting
// - per-output polarity inversion
// - fault brake stops normal drive
`default_nettype none

package pwm_pkg;
    localparam int NUM_CH   = 6;
    localparam int NUM_PAIR = 3;
    localparam int CNT_W    = 16;
    localparam int PRE_W    = 8;
    localparam int DIV_W    = 3;
    localparam int DZ_W     = 8;
    localparam int MODE_W   = 2;

    // pair modes
    localparam logic [MODE_W-1:0] MODE_INDEP = 2'h0;
    localparam logic [MODE_W-1:0] MODE_COMP  = 2'h1;
    localparam logic [MODE_W-1:0] MODE_SYNC  = 2'h2;

    // reset values
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [PRE_W-1:0] PRE_RST = 8'h00;
    localparam logic [DZ_W-1:0]  DZ_RST  = 8'h00;
    localparam logic [3:0]       DIV_RST = 4'h0;
endpackage : pwm_pkg

`default_nettype wire

// ==== verilog/pwm_chan_if.sv ====
// carrier between the unit's top and one waveform generator
// assumes the top drives controls and the generator answers
`default_nettype none

interface pwm_chan_if;
    logic                         tick;
    logic                         enable;
    logic                         oneshot;
    logic                         center;
    logic [pwm_pkg::DIV_W-1:0]    div_sel;
    logic [pwm_pkg::CNT_W-1:0]    period_buf;
    logic [pwm_pkg::CNT_W-1:0]    duty_buf;
    logic                         wave;
    logic                         period_hit;
    logic                         duty_hit;

    modport ctl  (output tick, enable, oneshot, center, div_sel, period_buf, duty_buf,
                  input wave, period_hit, duty_hit);
    modport chan (input tick, enable, oneshot, center, div_sel, period_buf, duty_buf,
                  output wave, period_hit, duty_hit);
endinterface : pwm_chan_if

`default_nettype wire

// ==== verilog/pwm_channel.sv ====
// one waveform generator: divider, down counter, duty compare
// assumes a one-cycle prescaler tick from the top of the unit
`default_nettype none

module pwm_channel (
    input  wire logic   clk,
    input  wire logic   rst,
    pwm_chan_if.chan    c
);
    localparam logic [pwm_pkg::CNT_W-1:0] CNT0 = pwm_pkg::CNT_RST;
    localparam logic [pwm_pkg::CNT_W-1:0] CNT1 = 16'h0001;

    logic [3:0]                  div_q;
    logic [pwm_pkg::CNT_W-1:0]   cnt_q;
    logic [pwm_pkg::CNT_W-1:0]   period_q;
    logic [pwm_pkg::CNT_W-1:0]   duty_q;
    logic                        up_q;
    logic                        run_q;
    logic                        done_q;
    logic                        wave_q;
    logic [3:0]                  mask;
    logic                        step;
    logic                        oneshot_eff;
    logic                        at_end;
    logic                        period_end;

    // divider mask: ratio 1 << div_sel, anything above 4 gives 1/16
    assign mask        = (4'h1 << c.div_sel) - 4'h1;
    assign step        = c.tick & run_q & ((div_q & mask) == 4'h0);
    assign oneshot_eff = c.oneshot & ~c.center;
    assign at_end      = c.center ? (up_q & (cnt_q >= period_q)) : (cnt_q == CNT0);
    assign period_end  = step & at_end;
    assign c.period_hit = period_end;
    assign c.duty_hit   = step & (cnt_q == duty_q);
    assign c.wave       = wave_q;

    // prescaled ticks advance the divider
    always_ff @(posedge clk) begin
        if (rst || !run_q) div_q <= pwm_pkg::DIV_RST;
        else if (c.tick) div_q <= div_q + 4'h1;
    end

    // run control; edge-mode one-shot stops after its first period, centre mode ignores the one-shot bit
    always_ff @(posedge clk) begin
        if (rst || !c.enable) begin
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end else if (period_end && oneshot_eff) begin
            run_q  <= 1'b0;
            done_q <= 1'b1;
        end else begin
            run_q  <= ~done_q;
        end
    end

    // down count, centre mode turns round at zero; buffers load at period end
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q    <= CNT0;
            period_q <= CNT0;
            duty_q   <= CNT0;
            up_q     <= 1'b0;
        end else if (!run_q || period_end) begin
            cnt_q    <= c.period_buf;
            period_q <= c.period_buf;
            duty_q   <= c.duty_buf;
            up_q     <= 1'b0;
        end else if (step) begin
            if (c.center && !up_q && cnt_q == CNT0) begin
                up_q  <= 1'b1;
                cnt_q <= CNT1;
            end else if (up_q && c.center) cnt_q <= cnt_q + CNT1; // no up-count once centre is off
            else cnt_q <= cnt_q - CNT1;
        end
    end

    // active while the count is below the duty value
    always_ff @(posedge clk) begin
        if (rst) wave_q <= 1'b0;
        else wave_q <= run_q & (cnt_q < duty_q);
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_reload;
        period_end |=> (period_q == $past(c.period_buf)) && (duty_q == $past(c.duty_buf));
    endproperty
    a_reload: assert property (p_reload) else $error("buffers not loaded at period end");

    property p_oneshot;
        (period_end && c.oneshot && !c.center && c.enable) |=> !run_q ##1 !run_q;
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("one-shot kept running");

    property p_down;
        (step && !c.center && !period_end && run_q) |=> cnt_q == $past(cnt_q) - CNT1;
    endproperty
    a_down: assert property (p_down) else $error("edge counter not counting down");

    property p_div;
        (step && c.div_sel == 3'h1) |-> div_q[0] == 1'b0;
    endproperty
    a_div: assert property (p_div) else $error("half-rate step on odd tick");

    c_center: cover property (period_end && c.center);
    c_oneshot: cover property (period_end && oneshot_eff);
endmodule : pwm_channel

`default_nettype wire

// ==== verilog/six_channel_motor_pwm.sv ====
// top of the six-channel motor waveform unit
// assumes control bits arrive as plain synchronous ports, no register bus
`default_nettype none

module six_channel_motor_pwm #(
    parameter int CNT_W = pwm_pkg::CNT_W,
    parameter int PRE_W = pwm_pkg::PRE_W,
    parameter int DZ_W  = pwm_pkg::DZ_W
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic [pwm_pkg::MODE_W-1:0]  pair_mode,
    input  wire logic                        group_en,
    input  wire logic                        center_en,
    input  wire logic [5:0]                  ch_enable,
    input  wire logic [5:0]                  oneshot,
    input  wire logic [17:0]                 div_sel,
    input  wire logic [3*PRE_W-1:0]          prescale,
    input  wire logic [3*DZ_W-1:0]           dead_zone,
    input  wire logic [5:0]                  invert,
    input  wire logic [5:0]                  period_wr,
    input  wire logic [5:0]                  duty_wr,
    input  wire logic [CNT_W-1:0]            wr_data,
    input  wire logic [5:0]                  int_en_period,
    input  wire logic [5:0]                  int_en_duty,
    input  wire logic [5:0]                  clr_period_flag,
    input  wire logic [5:0]                  clr_duty_flag,
    input  wire logic                        fault_in,
    input  wire logic                        brake_clr,
    output logic                             wave_out_0,
    output logic                             wave_out_1,
    output logic                             wave_out_2,
    output logic                             wave_out_3,
    output logic                             wave_out_4,
    output logic                             wave_out_5,
    output logic [5:0]                       period_flag,
    output logic [5:0]                       duty_flag,
    output logic                             irq,
    output logic                             brake_active
);
    logic [CNT_W-1:0]  period_buf_q [6];
    logic [CNT_W-1:0]  duty_buf_q [6];
    logic [PRE_W-1:0]  pre_cnt_q [3];
    logic [2:0]        pre_tick;
    logic [DZ_W-1:0]   dz_q [3];
    logic [2:0]        prev_q;
    logic [5:0]        raw;
    logic [5:0]        phit;
    logic [5:0]        dhit;
    logic [5:0]        pre_pol;
    logic [5:0]        wave_d;
    logic [5:0]        wave_q;
    logic [5:0]        period_flag_q;
    logic [5:0]        period_flag_d;
    logic [5:0]        duty_flag_q;
    logic [5:0]        duty_flag_d;
    logic              irq_q;
    logic              irq_d;
    logic              brake_q;
    logic              brake_d;
    logic              is_comp;
    logic              is_sync;

    assign is_comp = (pair_mode == pwm_pkg::MODE_COMP);
    assign is_sync = (pair_mode == pwm_pkg::MODE_SYNC);

    pwm_chan_if cif [6] ();

    // six generators, each with its own buffers and flags
    genvar i;
    generate
        for (i = 0; i < 6; i++) begin : g_ch
            // pair prescaler tick shared by both channels of the pair
            assign cif[i].tick       = pre_tick[i/2];
            assign cif[i].enable     = ch_enable[i];
            assign cif[i].oneshot    = oneshot[i];
            assign cif[i].center     = center_en;
            assign cif[i].div_sel    = div_sel[3*i +: 3];
            assign cif[i].period_buf = period_buf_q[i];
            assign cif[i].duty_buf   = duty_buf_q[i];
            assign raw[i]            = cif[i].wave;
            assign phit[i]           = cif[i].period_hit;
            assign dhit[i]           = cif[i].duty_hit;

            pwm_channel u_ch (
                .clk (clk),
                .rst (rst),
                .c   (cif[i])
            );

            // software writes land in the buffer only
            always_ff @(posedge clk) begin
                if (rst) begin
                    period_buf_q[i] <= pwm_pkg::CNT_RST;
                    duty_buf_q[i]   <= pwm_pkg::CNT_RST;
                end else begin
                    if (period_wr[i]) period_buf_q[i] <= wr_data;
                    if (duty_wr[i]) duty_buf_q[i] <= wr_data;
                end
            end
        end
    endgenerate

    // per-pair prescaler and dead zone
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_pair
            logic src_e;
            logic src_o;
            logic dz_ok;
            logic edge_e;

            // divide by prescale + 1
            assign pre_tick[p] = (pre_cnt_q[p] == pwm_pkg::PRE_RST);

            always_ff @(posedge clk) begin
                if (rst || pre_tick[p]) pre_cnt_q[p] <= prescale[PRE_W*p +: PRE_W];
                else pre_cnt_q[p] <= pre_cnt_q[p] - 8'h01;
            end

            // group control routes the first pair's timing to the others
            assign src_e  = (group_en && p != 0) ? raw[0] : raw[2*p];
            assign src_o  = (group_en && p != 0) ? raw[1] : raw[2*p+1];
            assign edge_e = (src_e != prev_q[p]);
            assign dz_ok  = !edge_e && (dz_q[p] == pwm_pkg::DZ_RST);

            // dead-zone count restarts on every edge of the leading output in complementary mode
            always_ff @(posedge clk) begin
                if (rst) begin
                    prev_q[p] <= 1'b0;
                    dz_q[p]   <= pwm_pkg::DZ_RST;
                end else begin
                    prev_q[p] <= src_e;
                    if (edge_e && is_comp) dz_q[p] <= dead_zone[DZ_W*p +: DZ_W];
                    else if (dz_q[p] != pwm_pkg::DZ_RST) dz_q[p] <= dz_q[p] - 8'h01;
                end
            end

            // pair shaping before polarity
            assign pre_pol[2*p]   = is_comp ? (src_e & dz_ok) : src_e;
            assign pre_pol[2*p+1] = is_comp ? (~src_e & dz_ok) :
                                    is_sync ? src_e : src_o;
        end
    endgenerate

    // polarity, then brake override to the inactive level
    assign wave_d = brake_q ? invert : (pre_pol ^ invert);

    // sticky flags: a match in the clearing cycle wins
    assign period_flag_d = phit | (period_flag_q & ~clr_period_flag);
    assign duty_flag_d   = dhit | (duty_flag_q & ~clr_duty_flag);
    assign irq_d = |((period_flag_d & int_en_period) | (duty_flag_d & int_en_duty));

    // brake latches on fault, clears only when software asks with fault gone
    assign brake_d = fault_in | (brake_q & ~brake_clr);

    always_ff @(posedge clk) begin
        if (rst) begin
            wave_q        <= 6'h00;
            period_flag_q <= 6'h00;
            duty_flag_q   <= 6'h00;
            irq_q         <= 1'b0;
            brake_q       <= 1'b0;
        end else begin
            wave_q        <= wave_d;
            period_flag_q <= period_flag_d;
            duty_flag_q   <= duty_flag_d;
            irq_q         <= irq_d;
            brake_q       <= brake_d;
        end
    end

    // outputs straight from flops
    assign wave_out_0   = wave_q[0];
    assign wave_out_1   = wave_q[1];
    assign wave_out_2   = wave_q[2];
    assign wave_out_3   = wave_q[3];
    assign wave_out_4   = wave_q[4];
    assign wave_out_5   = wave_q[5];
    assign period_flag  = period_flag_q;
    assign duty_flag    = duty_flag_q;
    assign irq          = irq_q;
    assign brake_active = brake_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_flag;
        (|phit) |=> ((period_flag_q & $past(phit)) == $past(phit));
    endproperty
    a_flag: assert property (p_flag) else $error("period match lost");

    property p_irq;
        (|((period_flag_q & $past(int_en_period)) | (duty_flag_q & $past(int_en_duty))))
            |-> irq_q;
    endproperty
    a_irq: assert property (p_irq) else $error("enabled flag without interrupt");

    property p_irq_mask;
        (int_en_period == 6'h00 && int_en_duty == 6'h00) |=> !irq_q;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt raised");

    property p_brake;
        brake_q |=> wave_q == $past(invert);
    endproperty
    a_brake: assert property (p_brake) else $error("brake not forcing idle");

    property p_brake_hold;
        (brake_q && !brake_clr && !fault_in) |=> brake_q;
    endproperty
    a_brake_hold: assert property (p_brake_hold) else $error("brake dropped");

    property p_comp;
        (is_comp && !brake_q) |=> ((wave_q[0] ^ $past(invert[0]))
            & (wave_q[1] ^ $past(invert[1]))) == 1'b0;
    endproperty
    a_comp: assert property (p_comp) else $error("complementary pair overlap");

    property p_sync;
        (is_sync && !brake_q && invert[1:0] == 2'h0) |=> wave_q[0] == wave_q[1];
    endproperty
    a_sync: assert property (p_sync) else $error("synchronous pair out of phase");

    property p_group;
        (group_en && pair_mode == pwm_pkg::MODE_INDEP && !brake_q && invert[2] == 1'b0)
            |=> wave_q[2] == $past(raw[0]);
    endproperty
    a_group: assert property (p_group) else $error("output 2 not following 0");

    property p_presc;
        (pre_tick[0] && prescale[PRE_W-1:0] == 8'h01) |=> !pre_tick[0] ##1 pre_tick[0];
    endproperty
    a_presc: assert property (p_presc) else $error("prescaler ratio wrong");

    c_comp: cover property (is_comp && dz_q[0] != pwm_pkg::DZ_RST);
    c_brake: cover property (brake_q ##1 !brake_q);
    c_irq: cover property (irq_q && group_en);
endmodule : six_channel_motor_pwm

`default_nettype wire

// ==== testbench/gate_stage.sv ====
// gate-stage model: six power switches driven by the waveform outputs
// assumes pairs 0/1, 2/3, 4/5 form half bridges; it only observes the gates
`default_nettype none

module gate_stage (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [5:0] gate,
    input  wire logic       comp_mode,
    output var  int         shoot_cnt
);
    timeunit 1ns;
    timeprecision 1ps;

    // a half bridge with both switches on shorts the supply rail
    always @(posedge clk) begin
        if (rst) begin
            shoot_cnt <= 0;
        end else if (comp_mode && ((gate[0] && gate[1]) || (gate[2] && gate[3])
                     || (gate[4] && gate[5]))) begin
            shoot_cnt <= shoot_cnt + 1;
        end
    end
endmodule : gate_stage

`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for the six-channel motor waveform unit
// assumes the unit and a gate-stage model; every control is a plain port
`default_nettype none
`define CHK(name, exp, got) begin checked++; if ((got) !== (exp)) begin failures++; \
    $display("ERROR %s expected %0h seen %0h", name, exp, got); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                       clk = 1'b0;
    logic                       rst = 1'b1;
    logic [pwm_pkg::MODE_W-1:0] pair_mode = 2'h0;
    logic                       group_en = 1'b0, center_en = 1'b0;
    logic [5:0]                 ch_enable = 6'h00, oneshot = 6'h00, invert = 6'h00;
    logic [17:0]                div_sel = 18'h00000;
    logic [23:0]                prescale = 24'h000000, dead_zone = 24'h000000;
    logic [5:0]                 period_wr = 6'h00, duty_wr = 6'h00;
    logic [15:0]                wr_data = 16'h0000;
    logic [5:0]                 int_en_period = 6'h00, int_en_duty = 6'h00;
    logic [5:0]                 clr_period_flag = 6'h00, clr_duty_flag = 6'h00;
    logic                       fault_in = 1'b0, brake_clr = 1'b0;
    logic [5:0]                 w, period_flag, duty_flag;
    logic                       irq, brake_active;
    int                         failures = 0, checked = 0, cycles = 0, shoot_cnt, c[6], ds, dg;

    six_channel_motor_pwm six_channel_motor_pwm_inst (.clk(clk), .rst(rst),
        .pair_mode(pair_mode), .group_en(group_en), .center_en(center_en),
        .ch_enable(ch_enable), .oneshot(oneshot), .div_sel(div_sel), .prescale(prescale),
        .dead_zone(dead_zone), .invert(invert), .period_wr(period_wr), .duty_wr(duty_wr),
        .wr_data(wr_data), .int_en_period(int_en_period), .int_en_duty(int_en_duty),
        .clr_period_flag(clr_period_flag), .clr_duty_flag(clr_duty_flag),
        .fault_in(fault_in), .brake_clr(brake_clr), .wave_out_0(w[0]), .wave_out_1(w[1]),
        .wave_out_2(w[2]), .wave_out_3(w[3]), .wave_out_4(w[4]), .wave_out_5(w[5]),
        .period_flag(period_flag), .duty_flag(duty_flag), .irq(irq),
        .brake_active(brake_active));
    gate_stage gate_stage_inst (.clk(clk), .rst(rst), .gate(w),
        .comp_mode(pair_mode == pwm_pkg::MODE_COMP), .shoot_cnt(shoot_cnt));

    // clock and hang guard
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (failures == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // reset the unit and return the mode, enable, divider, prescale, dead-zone, interrupt-enable and fault controls to idle
    task automatic restart(input int n);
        @(posedge clk);
        rst <= 1'b1;
        {pair_mode, group_en, center_en, ch_enable, oneshot, invert} <= '0;
        {div_sel, prescale, dead_zone, int_en_period, int_en_duty, fault_in} <= '0;
        repeat (n) @(posedge clk);
        rst <= 1'b0;
    endtask : restart

    // one-cycle buffer write strobe
    task automatic wr(input int ch, input bit duty, input logic [15:0] v);
        @(posedge clk);
        wr_data <= v;
        if (duty) duty_wr <= 6'h01 << ch; else period_wr <= 6'h01 << ch;
        @(posedge clk);
        {period_wr, duty_wr} <= 12'h000;
    endtask : wr

    task automatic waitn(input int n);
        repeat (n) @(negedge clk);
    endtask : waitn

    // high cycles per output, and sync / group mismatch cycles
    task automatic count(input int n);
        c = '{default: 0};
        ds = 0;
        dg = 0;
        repeat (n) begin
            @(negedge clk);
            for (int b = 0; b < 6; b++) c[b] += int'(w[b] === 1'b1);
            ds += int'(w[0] !== w[1]);
            dg += int'(w[3:2] !== w[1:0] || w[5:4] !== w[1:0]);
        end
    endtask : count

    // length in clocks of the next whole active pulse on output 0
    task automatic run_len(output int len);
        int g;
        g = 0;
        len = 0;
        while (w[0] === 1'b1 && g < 300) begin @(negedge clk); g++; end
        while (w[0] !== 1'b1 && g < 600) begin @(negedge clk); g++; end
        while (w[0] === 1'b1 && len < 300) begin @(negedge clk); len++; end
    endtask : run_len

    // channel 0: period 9 (ten steps), duty 4
    task automatic start0();
        wr(0, 1'b0, 16'h0009);
        wr(0, 1'b1, 16'h0004);
        ch_enable <= ch_enable | 6'h01;
    endtask : start0

    task automatic t_divider();
        restart(10);
        `CHK("reset outputs", 6'h00, w)
        `CHK("reset flags", 12'h000, {period_flag, duty_flag})
        prescale <= 24'h000001;
        start0();
        for (int r = 0; r < 5; r++) begin
            @(posedge clk) div_sel <= 18'(r);
            waitn(40 << r);
            count(40 << r);
            `CHK("divided highs", 16 << r, c[0])
        end
    endtask : t_divider

    task automatic t_buffer();
        int len;
        restart(2);
        start0();
        waitn(30);
        wr(0, 1'b1, 16'h0002);
        for (int k = 0; k < 5; k++) begin
            run_len(len);
            `CHK("whole pulse", 1'b1, len == 4 || len == 2)
        end
        `CHK("new duty", 2, len)
    endtask : t_buffer

    task automatic t_flags();
        restart(2);
        start0();
        waitn(30);
        `CHK("period flag", 2'h3, {period_flag[0], duty_flag[0]})
        `CHK("idle flag", 1'b0, period_flag[1])
        `CHK("masked irq", 1'b0, irq)
        @(posedge clk) int_en_period <= 6'h01;
        ch_enable <= 6'h00;
        waitn(3);
        `CHK("period irq", 1'b1, irq)
        @(posedge clk) clr_period_flag <= 6'h01;
        @(posedge clk) clr_period_flag <= 6'h00;
        waitn(2);
        `CHK("cleared flag", 3'h2, {period_flag[0], duty_flag[0], irq})
        @(posedge clk) int_en_duty <= 6'h01;
        waitn(3);
        `CHK("enabled irq", 1'b1, irq)
        @(posedge clk) clr_duty_flag <= 6'h01;
        @(posedge clk) clr_duty_flag <= 6'h00;
        waitn(3);
        `CHK("irq dropped", 1'b0, irq)
    endtask : t_flags

    task automatic t_modes();
        int len;
        restart(2);
        oneshot <= 6'h01;
        start0();
        waitn(40);
        count(50);
        `CHK("one-shot stopped", 0, c[0])
        restart(2);
        center_en <= 1'b1;
        oneshot <= 6'h01;
        start0();
        waitn(60);
        for (int k = 0; k < 2; k++) begin
            run_len(len);
            `CHK("centre pulse", 7, len)
        end
    endtask : t_modes

    task automatic t_pairs();
        restart(2);
        pair_mode <= pwm_pkg::MODE_COMP;
        dead_zone <= 24'h000001;
        start0();
        wr(1, 1'b0, 16'h0009);
        wr(1, 1'b1, 16'h0004);
        ch_enable <= 6'h03;
        waitn(30);
        count(100);
        `CHK("comp highs", 60, c[0] + c[1])
        `CHK("no overlap", 0, shoot_cnt)
        @(posedge clk) pair_mode <= pwm_pkg::MODE_SYNC;
        waitn(30);
        count(100);
        `CHK("sync highs", 40, c[0])
        `CHK("sync phase", 0, ds)
        @(posedge clk) pair_mode <= pwm_pkg::MODE_INDEP;
        group_en <= 1'b1;
        wr(1, 1'b1, 16'h0007);
        ch_enable <= 6'h3F;
        waitn(30);
        count(100);
        `CHK("ch1 highs", 70, c[1])
        `CHK("group follow", 0, dg)
    endtask : t_pairs

    task automatic t_brake();
        restart(2);
        invert <= 6'h21;
        start0();
        waitn(30);
        count(100);
        `CHK("inverted highs", 60, c[0])
        `CHK("idle inverted", 100, c[5])
        @(posedge clk) fault_in <= 1'b1;
        waitn(3);
        `CHK("brake on", 1'b1, brake_active)
        count(20);
        `CHK("brake level", 20, c[0] + c[1])
        @(posedge clk) brake_clr <= 1'b1;
        @(posedge clk) brake_clr <= 1'b0;
        @(posedge clk) fault_in <= 1'b0;
        waitn(3);
        `CHK("brake held", 6'h21, {brake_active, w[4:0]})
        @(posedge clk) brake_clr <= 1'b1;
        @(posedge clk) brake_clr <= 1'b0;
        waitn(30);
        count(100);
        `CHK("brake released", 61, c[0] + int'(brake_active === 1'b0))
    endtask : t_brake

    initial begin
        t_divider();
        t_buffer();
        t_flags();
        t_modes();
        t_pairs();
        t_brake();
        complete_run();
    end
endmodule : tb

`default_nettype wire
